//--- logic/mac_regs.vh
// Constants for the 16x16 multiplier-accumulator
`ifndef MAC_REGS_VH
`define MAC_REGS_VH
`define MAC_OP_W      16
`define MAC_ACC_W     35
`define MAC_LOW_LSB   0
`define MAC_LOW_MSB   15
`define MAC_HIGH_LSB  16
`define MAC_HIGH_MSB  31
`define MAC_EXT_LSB   32
`define MAC_EXT_MSB   34
`define MAC_ACC_RST   35'h000000000
`define MAC_OP_RST    16'h0000
`endif

//--- logic/mac_core.v
// 16x16 multiplier-accumulator with 35-bit preloadable accumulator
`timescale 1ns/100ps
`default_nettype none
`include "mac_regs.vh"

module mac_core
(
  input  wire        mclk,                  // Clock, 40 MHz
  input  wire        resetn,                // Synchronous reset, active low
  input  wire [15:0] x_in,                  // X operand
  input  wire [15:0] y_in,                  // Y pins, input side
  output reg  [15:0] y_out,                 // Y pins, low part out
  output reg         y_oe,                  // Y pins drive enable
  input  wire        x_signed,              // X is two's complement
  input  wire        y_signed,              // Y is two's complement
  input  wire        accumulate_select,     // Accumulate instead of load
  input  wire        sub_select,            // Subtract when accumulating
  input  wire        preload_select,        // Preload accumulator from pins
  input  wire        low_out_en,            // Show low part on Y pins
  input  wire        high_out_en,           // Enable high part drivers
  input  wire        ext_out_en,            // Enable extension drivers
  input  wire [15:0] high_in,               // High part pins, input side
  input  wire [2:0]  ext_in,                // Extension pins, input side
  output reg  [15:0] result_high_part,      // High part pins, output
  output reg         high_oe,               // High part drive enable
  output reg  [2:0]  result_extension_part, // Extension pins, output
  output reg         ext_oe                 // Extension drive enable
);

  // Accumulator function codes, decoded from the registered controls and the unregistered preload_select
  localparam [1:0] FN_LOAD    = 2'b00;
  localparam [1:0] FN_ADD     = 2'b01;
  localparam [1:0] FN_SUB     = 2'b10;
  localparam [1:0] FN_PRELOAD = 2'b11;

  reg  [15:0] x_ff;
  reg  [15:0] y_ff;
  reg         xs_ff;
  reg         ys_ff;
  reg         acc_ff;
  reg         sub_ff;
  reg  [1:0]  fn_sel;
  reg  [34:0] acc_reg_ff;
  reg  [34:0] nxt_acc;
  wire [16:0] x_ext;
  wire [16:0] y_ext;
  wire [34:0] x_wide;
  wire [34:0] pp_row [0:16];
  wire [34:0] pp_sum [0:17];
  wire [34:0] prod;
  wire [34:0] preload_word;
  genvar      gi;

  // Operands and controls are taken at one edge; the accumulator and its
  // output copies change at the next. Preload alone skips the control
  // registers, so the pin value lands at the edge where preload is seen.

  // Operand input registers; Y is only taken while low_out_en is low
  always @(posedge mclk)
  begin
    if (!resetn)
    begin
      x_ff <= `MAC_OP_RST;
      y_ff <= `MAC_OP_RST;
    end
    else
    begin
      x_ff <= x_in;
      if (!low_out_en)
        y_ff <= y_in;
    end
  end

  // Format and function control registers
  always @(posedge mclk)
  begin
    if (!resetn)
    begin
      xs_ff  <= 1'b0;
      ys_ff  <= 1'b0;
      acc_ff <= 1'b0;
      sub_ff <= 1'b0;
    end
    else
    begin
      xs_ff  <= x_signed;
      ys_ff  <= y_signed;
      acc_ff <= accumulate_select;
      sub_ff <= sub_select;
    end
  end

  // Extend each operand by one bit so one signed multiply covers all formats
  assign x_ext     = {xs_ff & x_ff[15], x_ff};
  assign y_ext     = {ys_ff & y_ff[15], y_ff};
  assign x_wide    = {{18{x_ext[16]}}, x_ext};
  assign pp_sum[0] = 35'h000000000;

  // Shift-and-add array, one row per Y bit; the Y sign row has negative weight
  generate
    for (gi = 0; gi < 17; gi = gi + 1)
    begin : g_row
      assign pp_row[gi] = y_ext[gi] ? (x_wide << gi) : 35'h000000000;
      if (gi == 16)
      begin : g_sign
        assign pp_sum[gi + 1] = pp_sum[gi] - pp_row[gi];
      end
      else
      begin : g_mag
        assign pp_sum[gi + 1] = pp_sum[gi] + pp_row[gi];
      end
    end
  endgenerate

  // Product is already sign-extended over the whole accumulator width
  assign prod         = pp_sum[17];
  assign preload_word = {ext_in, high_in, y_in};

  // Function select; preload wins over any operation in progress
  always @*
  begin
    if (preload_select)
      fn_sel = FN_PRELOAD;
    else if (!acc_ff)
      fn_sel = FN_LOAD;
    else if (sub_ff)
      fn_sel = FN_SUB;
    else
      fn_sel = FN_ADD;
  end

  always @*
  begin
    case (fn_sel)
      FN_LOAD:
        nxt_acc = prod;
      FN_ADD:
        nxt_acc = acc_reg_ff + prod;
      FN_SUB:
        nxt_acc = acc_reg_ff - prod;
      FN_PRELOAD:
        nxt_acc = preload_word;
      default:
        nxt_acc = acc_reg_ff;
    endcase
  end

  // Accumulator
  always @(posedge mclk)
  begin
    if (!resetn)
      acc_reg_ff <= `MAC_ACC_RST;
    else
      acc_reg_ff <= nxt_acc;
  end

  // Output copies of the accumulator parts
  always @(posedge mclk)
  begin
    if (!resetn)
    begin
      y_out                 <= `MAC_OP_RST;
      result_high_part      <= `MAC_OP_RST;
      result_extension_part <= 3'h0;
    end
    else
    begin
      y_out                 <= nxt_acc[`MAC_LOW_MSB:`MAC_LOW_LSB];
      result_high_part      <= nxt_acc[`MAC_HIGH_MSB:`MAC_HIGH_LSB];
      result_extension_part <= nxt_acc[`MAC_EXT_MSB:`MAC_EXT_LSB];
    end
  end

  // Drive enables, all forced off while preload owns the pins
  always @(posedge mclk)
  begin
    if (!resetn)
    begin
      y_oe    <= 1'b0;
      high_oe <= 1'b0;
      ext_oe  <= 1'b0;
    end
    else
    begin
      y_oe    <= low_out_en & ~preload_select;
      high_oe <= high_out_en & ~preload_select;
      ext_oe  <= ext_out_en & ~preload_select;
    end
  end

endmodule
`default_nettype wire

//--- testbench/mac_core_monitor.sv
// Port checker for the multiplier-accumulator
`timescale 1ns/100ps
`default_nettype none
module mac_core_monitor (input wire mclk, resetn, x_signed, y_signed, accumulate_select,
  sub_select, preload_select, low_out_en, high_out_en, ext_out_en, y_oe, high_oe, ext_oe,
  input wire [15:0] x_in, y_in, y_out, high_in, result_high_part,
  input wire [2:0] ext_in, result_extension_part);
  wire [34:0] a = {result_extension_part, result_high_part, y_out};
  wire [34:0] p = $signed({x_signed & x_in[15], x_in}) * $signed({y_signed & y_in[15], y_in});
  wire c = accumulate_select, s = sub_select, pl = preload_select, g = !pl && !low_out_en;
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  a_load_product: assert property (g && !c ##1 !pl |=> a == $past(p, 2))
    else $error("bad load");
  a_add_product: assert property (g && c && !s ##1 !pl |=> a == $past(a) + $past(p, 2))
    else $error("bad add");
  a_sub_product: assert property (g && c && s ##1 !pl |=> a == $past(a) - $past(p, 2))
    else $error("bad sub");
  a_preload_take: assert property (pl |=> a == $past({ext_in, high_in, y_in}))
    else $error("bad preload");
  a_preload_off: assert property (pl |=> !y_oe && !high_oe && !ext_oe)
    else $error("driver on");
  a_low_drive: assert property (1 |=> y_oe == $past(low_out_en && !pl))
    else $error("bad y_oe");
  a_high_drive: assert property (1 |=> high_oe == $past(high_out_en && !pl))
    else $error("bad high_oe");
  a_ext_drive: assert property (1 |=> ext_oe == $past(ext_out_en && !pl))
    else $error("bad ext_oe");
endmodule
bind mac_core mac_core_monitor u_mon (.*);
`default_nettype wire

//--- testbench/mac_host_model.sv
// Host side of the shared result pins
`timescale 1ns/100ps
`default_nettype none
module mac_host_model (input wire [34:0] dv, hv, input wire [2:0] oe, input wire he,
  output wire [34:0] pin);
  // A released pin reads back hv while he is set, else inverted so stale data never matches
  assign pin[15:0] = oe[0] ? dv[15:0] : he ? hv[15:0] : ~dv[15:0];
  assign pin[31:16] = oe[1] ? dv[31:16] : he ? hv[31:16] : ~dv[31:16];
  assign pin[34:32] = oe[2] ? dv[34:32] : he ? hv[34:32] : ~dv[34:32];
endmodule
`default_nettype wire

//--- testbench/mac_core_tb_top.sv
// Self-checking bench for the multiplier-accumulator
`timescale 1ns/100ps
`default_nettype none
module mac_core_tb_top;
  reg mclk = 0, rn = 0, xs = 0, ys = 0, ac = 0, sb = 0, pl = 0, en = 0, he = 0;
  reg [15:0] x = 16'h0;
  reg [34:0] hv = 35'h0;
  wire [34:0] pin, acc;
  wire [2:0] oe;
  integer n_errors = 0, check_count = 0;
  always #12.5 mclk = ~mclk;
  mac_core dut (.mclk(mclk), .resetn(rn), .x_in(x), .y_in(pin[15:0]), .y_out(acc[15:0]),
    .y_oe(oe[0]), .x_signed(xs), .y_signed(ys), .accumulate_select(ac), .sub_select(sb),
    .preload_select(pl), .low_out_en(en), .high_out_en(en), .ext_out_en(en),
    .high_in(pin[31:16]), .ext_in(pin[34:32]), .result_high_part(acc[31:16]),
    .high_oe(oe[1]), .result_extension_part(acc[34:32]), .ext_oe(oe[2]));
  mac_host_model host (.dv(acc), .hv(hv), .oe(oe), .he(he), .pin(pin));
  task chk(input [34:0] g, e);
    begin
      check_count = check_count + 1;
      if (g !== e) begin n_errors = n_errors + 1; $display("MISMATCH %0t %h", $time, g); end
    end
  endtask
  task op(input [15:0] a, b, input [1:0] s, input c, d, input [34:0] e);
    begin
      @(posedge mclk); pl <= 0; en <= 0; he <= 1; x <= a; hv <= {19'h0, b};
      {xs, ys} <= s; ac <= c; sb <= d;
      repeat (2) @(posedge mclk);
      #1 chk(acc, e);
    end
  endtask
  task end_of_test;
    begin
      $display("errors %0d checks %0d", n_errors, check_count);
      if (n_errors == 0 && check_count > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  initial begin
    #5000 n_errors = n_errors + 1;
    end_of_test;
  end
  initial begin
    repeat (16) @(posedge mclk); rn <= 1;
    op(16'hffff, 16'hffff, 0, 0, 0, 35'h0fffe0001);
    op(16'hffff, 16'h0003, 2'b11, 0, 0, 35'h7fffffffd);
    op(16'h0002, 16'h0003, 0, 1, 0, 35'h000000003);
    op(16'h0000, 16'h0000, 0, 0, 0, 35'h000000000);
    op(16'h0001, 16'h0001, 0, 1, 1, 35'h7ffffffff);
    op(16'hffff, 16'hffff, 2'b01, 0, 0, 35'h7ffff0001);
    @(posedge mclk); pl <= 1; en <= 1; hv <= 35'h5a5a5c3c3;
    @(posedge mclk); #1 chk(acc, 35'h5a5a5c3c3);
    chk({32'h0, oe}, 35'h0);
    op(16'h0100, 16'h0100, 0, 0, 0, 35'h000010000);
    @(posedge mclk); en <= 1; he <= 0;
    repeat (2) @(posedge mclk);
    #1 chk(pin, 35'h000010000);
    chk({32'h0, oe}, 35'h7);
    end_of_test;
  end
endmodule
`default_nettype wire
